// ===== hdl/lpw_target.sv
`timescale 1ns/1ns
`default_nettype none
module lpw_target
    import lpw_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    lpw_bus_if.device bus,
    input wire logic [15:0] io_base,
    input wire logic slow_io,
    input wire logic slow_ready,
    input wire logic err_inject,
    input wire logic dma_want,
    input wire logic [1:0] dma_chan,
    input wire logic [7:0] src_data,
    input wire logic src_valid,
    output logic src_ready,
    output logic [7:0] snk_data,
    output logic snk_valid,
    input wire logic snk_ready,
    output logic cyc_done,
    output logic cyc_error
);
    // ----------------------------------------------------------------
    // State machine
    // ----------------------------------------------------------------
    typedef enum logic [10:0] {
        ST_IDLE = 11'h001,
        ST_TYPE = 11'h002,
        ST_ADDR = 11'h004,
        ST_CHAN = 11'h008,
        ST_SIZE = 11'h010,
        ST_WDAT = 11'h020,
        ST_TAR1 = 11'h040,
        ST_SYNC = 11'h080,
        ST_RDAT = 11'h100,
        ST_TAR2 = 11'h200,
        ST_SKIP = 11'h400
    } lpw_state_t;
    lpw_state_t st_q, st_d;
    logic [3:0] ct_q;
    logic [15:0] addr_q;
    logic [2:0] cnt_q;
    logic [1:0] bytes_q;
    logic [7:0] data_q;
    logic [9:0] wait_q;
    logic err_q;
    logic [3:0] dout_q;
    logic oe_q;
    logic [2:0] dreq_q;
    logic [7:0] fifo_d;
    logic fifo_v;
    logic fifo_rdy;
    wire in_rst = !bus.bus_reset_n;
    wire frame = !bus.frame_n && !in_rst;
    wire [3:0] lad = bus.lad;
    wire is_dma = ct_q[3];
    wire is_wr = ct_q[1];
    // Device drives sync on DMA cycles and on I/O cycles that hit io_base, reads and writes alike (dev_sync tied high)
    wire dev_sync = 1'b1;
    wire type_ok = (lad == LPW_CT_IO_RD) || (lad == LPW_CT_IO_WR) ||
        (lad == LPW_CT_DMA_RD) || (lad == LPW_CT_DMA_WR);
    wire [9:0] wait_need = is_dma ? (is_wr ? LPW_WAIT_DMA_WR : LPW_WAIT_DMA_RD)
        : (is_wr ? LPW_WAIT_IO_WR : LPW_WAIT_IO_RD);
    // Host-to-device data: I/O write or DMA read, which sinks into the FIFO
    wire to_dev = is_dma ? !is_wr : is_wr;
    // Sync is registered: pick the next code from the next wait count, so the
    // state leaves sync exactly when ready or error stands on the wire
    wire [9:0] wait_nx = (st_q == ST_SYNC) ? wait_q + 10'h001 : 10'h000;
    // Slow I/O holds the long code until ready or timeout
    wire slow_hold = !is_dma && slow_io && !slow_ready && (wait_nx < LPW_LONG_MAX);
    wire blocked = to_dev ? (!fifo_rdy && !err_q) : !fifo_v;
    wire wait_more = (wait_nx < wait_need) || slow_hold || blocked;
    wire last_byte = !is_dma || (bytes_q == 2'h0) || err_q;
    wire [3:0] wait_code = is_dma ? LPW_SYNC_SHORT : LPW_SYNC_LONG;
    wire in_wait = (dout_q == wait_code);
    wire [3:0] ready_code = (is_dma && !last_byte) ? LPW_SYNC_READY_MORE : LPW_SYNC_READY;
    wire hit = (addr_q == io_base);
    assign src_ready = (st_q == ST_SYNC) && !in_wait && !to_dev && fifo_v;
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: st_d = ST_IDLE;
            ST_TYPE: st_d = type_ok ? (lad[3] ? ST_CHAN : ST_ADDR) : ST_SKIP;
            ST_ADDR: st_d = (cnt_q == 3'h3) ? (is_wr ? ST_WDAT : ST_TAR1) : ST_ADDR;
            ST_CHAN: st_d = ST_SIZE;
            ST_SIZE: st_d = (!is_wr) ? ST_WDAT : ST_TAR1;
            ST_WDAT: st_d = (cnt_q == 3'h1) ? ST_TAR1 : ST_WDAT;
            ST_TAR1: st_d = (cnt_q == 3'h1) ? (hit || is_dma ? ST_SYNC : ST_SKIP) : ST_TAR1;
            ST_SYNC: st_d = in_wait ? ST_SYNC
                : (to_dev ? (last_byte ? ST_TAR2 : ST_WDAT) : ST_RDAT);
            ST_RDAT: st_d = (cnt_q == 3'h1) ? (last_byte ? ST_TAR2 : ST_SYNC) : ST_RDAT;
            ST_TAR2: st_d = (cnt_q == 3'h1) ? ST_IDLE : ST_TAR2;
            ST_SKIP: st_d = ST_SKIP;
            default: st_d = ST_IDLE;
        endcase
        if (frame) begin
            st_d = (lad == LPW_START) ? ST_TYPE : ST_IDLE;
        end
    end
    // ----------------------------------------------------------------
    // Datapath
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset || in_rst) begin
            st_q <= ST_IDLE;
            ct_q <= '0;
            addr_q <= LPW_ADDR_DEFAULT;
            cnt_q <= '0;
            bytes_q <= '0;
            data_q <= '0;
            wait_q <= '0;
            err_q <= 1'b0;
            dout_q <= LPW_TAR;
            oe_q <= 1'b0;
            cyc_done <= 1'b0;
            cyc_error <= 1'b0;
        end else begin
            st_q <= st_d;
            cyc_done <= 1'b0;
            cyc_error <= 1'b0;
            cnt_q <= (st_d != st_q) ? 3'h0 : cnt_q + 3'h1;
            if (st_q == ST_TYPE) begin
                ct_q <= lad;
            end
            if (st_q == ST_ADDR) begin
                addr_q <= {addr_q[11:0], lad};
            end
            if (st_q == ST_SIZE) begin
                bytes_q <= (lad[1:0] == LPW_SZ_4) ? 2'h3 : lad[1:0];
            end
            if (st_q == ST_WDAT) begin
                data_q <= {lad, data_q[7:4]};
            end
            if (st_q == ST_TAR1) begin
                err_q <= err_inject;
            end
            if (st_q == ST_SYNC) begin
                wait_q <= wait_q + 10'h001;
                if (st_d != ST_SYNC) begin
                    wait_q <= '0;
                    if (src_ready) begin
                        data_q <= src_data;
                    end
                end
            end
            if (st_q == ST_RDAT && cnt_q == 3'h0) begin
                data_q <= {4'h0, data_q[7:4]};
            end
            if ((st_q == ST_SYNC || st_q == ST_RDAT) && st_d != st_q && !last_byte &&
                (st_d == ST_SYNC || st_d == ST_WDAT)) begin
                bytes_q <= bytes_q - 2'h1;
            end
            if (st_q == ST_TAR2 && st_d == ST_IDLE) begin
                cyc_done <= 1'b1;
                cyc_error <= err_q;
            end
            // Bus driver: registered so the release lands one clock after frame
            oe_q <= !frame && (st_d == ST_SYNC || st_d == ST_RDAT ||
                (st_q == ST_RDAT && st_d == ST_TAR2));
            if (st_d == ST_SYNC) begin
                dout_q <= wait_more ? wait_code
                    : (err_q ? LPW_SYNC_ERROR : ready_code);
            end else if (st_d == ST_RDAT) begin
                dout_q <= (st_q == ST_RDAT) ? data_q[7:4] : src_data[3:0];
            end else begin
                dout_q <= LPW_TAR;
            end
        end
    end
    // A write/DMA-read byte enters the FIFO once its sync ends with a ready code; an error sync pushes nothing
    assign fifo_v = src_valid;
    assign fifo_d = data_q;
    wire push = (st_q == ST_SYNC) && to_dev && !in_wait && fifo_rdy && !err_q;
    lpw_fifo #(.WIDTH(8), .DEPTH(LPW_FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .reset(reset),
        .in_data(fifo_d),
        .in_valid(push),
        .in_ready(fifo_rdy),
        .out_data(snk_data),
        .out_valid(snk_valid),
        .out_ready(snk_ready)
    );
    // ----------------------------------------------------------------
    // DMA request: start bit then channel, serialised
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset || in_rst) begin
            dreq_q <= '0;
        end else if (dreq_q != 3'h0) begin
            dreq_q <= dreq_q + 3'h1;
        end else if (dma_want && st_q == ST_IDLE) begin
            dreq_q <= 3'h1;
        end
    end
    assign bus.dma_req_n = (dreq_q == 3'h0) ? 1'b1 : (dreq_q == 3'h1) ? 1'b0 :
        (dreq_q == 3'h2) ? dma_chan[1] : (dreq_q == 3'h3) ? dma_chan[0] : 1'b1;
    assign bus.lad_d_o = dout_q;
    assign bus.lad_d_oe = oe_q && !in_rst && dev_sync;
endmodule
`default_nettype wire

// ===== hdl/lpw_pkg.sv
package lpw_pkg;
    // ----------------------------------------------------------------
    // Nibble codes on the shared bus
    // ----------------------------------------------------------------
    localparam logic [3:0] LPW_START = 4'h0;
    localparam logic [3:0] LPW_SYNC_READY = 4'h0;
    localparam logic [3:0] LPW_SYNC_READY_MORE = 4'h9;
    localparam logic [3:0] LPW_SYNC_SHORT = 4'h5;
    localparam logic [3:0] LPW_SYNC_LONG = 4'h6;
    localparam logic [3:0] LPW_SYNC_ERROR = 4'hA;
    localparam logic [3:0] LPW_TAR = 4'hF;
    // Cycle type nibbles, direction in bit 1, class in bits 3:2
    localparam logic [3:0] LPW_CT_IO_RD = 4'h0;
    localparam logic [3:0] LPW_CT_IO_WR = 4'h2;
    localparam logic [3:0] LPW_CT_DMA_RD = 4'h8;
    localparam logic [3:0] LPW_CT_DMA_WR = 4'hA;
    // DMA size nibbles
    localparam logic [1:0] LPW_SZ_1 = 2'h0;
    localparam logic [1:0] LPW_SZ_2 = 2'h1;
    localparam logic [1:0] LPW_SZ_4 = 2'h3;
    // ----------------------------------------------------------------
    // Wait state counts and limits
    // ----------------------------------------------------------------
    localparam logic [9:0] LPW_WAIT_IO_RD = 10'h003;
    localparam logic [9:0] LPW_WAIT_IO_WR = 10'h002;
    localparam logic [9:0] LPW_WAIT_DMA_RD = 10'h003;
    localparam logic [9:0] LPW_WAIT_DMA_WR = 10'h004;
    localparam logic [9:0] LPW_SHORT_MAX = 10'h008;
    localparam logic [9:0] LPW_LONG_MAX = 10'h14A;
    localparam logic [3:0] LPW_NO_SYNC_MAX = 4'h3;
    localparam int LPW_CLK_MHZ = 125;
    localparam int LPW_RESET_US = 100;
    localparam int LPW_RESET_CYCLES = LPW_RESET_US * LPW_CLK_MHZ;
    localparam logic [15:0] LPW_ADDR_DEFAULT = 16'h0000;
    localparam int LPW_FIFO_DEPTH = 8;
endpackage

// ===== hdl/lpw_bus_if.sv
`timescale 1ns/1ns
`default_nettype none
interface lpw_bus_if;
    logic [3:0] lad_h_o;
    logic lad_h_oe;
    logic [3:0] lad_d_o;
    logic lad_d_oe;
    logic frame_n;
    logic bus_reset_n;
    logic dma_req_n;
    wire [3:0] lad = lad_h_oe ? lad_h_o : (lad_d_oe ? lad_d_o : 4'hF);
    modport host (output lad_h_o, output lad_h_oe, output frame_n, output bus_reset_n,
        input lad, input dma_req_n);
    modport device (output lad_d_o, output lad_d_oe, output dma_req_n, input lad,
        input frame_n, input bus_reset_n);
endinterface
`default_nettype wire

// ===== hdl/lpw_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module lpw_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule
`default_nettype wire

// ===== hdl/lpw_host.sv
`timescale 1ns/1ns
`default_nettype none
module lpw_host
    import lpw_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    lpw_bus_if.host bus,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [3:0] req_type,
    input wire logic [15:0] req_addr,
    input wire logic [1:0] req_size,
    input wire logic [7:0] req_wdata,
    output logic [7:0] rsp_data,
    output logic rsp_valid,
    output logic rsp_error,
    output logic rsp_abort,
    output logic dma_seen
);
    // ----------------------------------------------------------------
    // Host sequencer: one nibble per clock
    // ----------------------------------------------------------------
    logic [5:0] step_q;
    logic busy_q;
    logic [3:0] ct_q;
    logic [15:0] addr_q;
    logic [7:0] wd_q;
    logic [7:0] rd_q;
    logic [3:0] nos_q;
    logic [1:0] left_q;
    logic [15:0] rst_cnt_q;
    logic [3:0] ph_q;
    wire rst_done = (rst_cnt_q == LPW_RESET_CYCLES[15:0]);
    wire is_dma = ct_q[3];
    wire to_dev = is_dma ? !ct_q[1] : ct_q[1];
    wire [3:0] lad = bus.lad;
    wire sync_ok = (lad == LPW_SYNC_READY) || (lad == LPW_SYNC_READY_MORE) ||
        (lad == LPW_SYNC_ERROR);
    wire sync_wait = (lad == LPW_SYNC_SHORT) || (lad == LPW_SYNC_LONG);
    assign req_ready = !busy_q && rst_done;
    assign bus.bus_reset_n = rst_done;
    // Phases: 0 start,1 type,2 addr/chan,3 size,4 wdata,5 tar,6 sync,7 rdata,8 tar
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rst_cnt_q <= '0;
            busy_q <= 1'b0;
            ph_q <= '0;
            step_q <= '0;
            ct_q <= '0;
            addr_q <= '0;
            wd_q <= '0;
            rd_q <= '0;
            nos_q <= '0;
            left_q <= '0;
            rsp_data <= '0;
            rsp_valid <= 1'b0;
            rsp_error <= 1'b0;
            rsp_abort <= 1'b0;
            dma_seen <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            rsp_abort <= 1'b0;
            dma_seen <= rst_done && !bus.dma_req_n;
            if (!rst_done) begin
                rst_cnt_q <= rst_cnt_q + 16'h0001;
            end else if (!busy_q) begin
                if (req_valid) begin
                    busy_q <= 1'b1;
                    ph_q <= 4'h0;
                    step_q <= '0;
                    ct_q <= req_type;
                    addr_q <= req_addr;
                    wd_q <= req_wdata;
                    left_q <= req_type[3] ? req_size : 2'h0;
                    rsp_error <= 1'b0;
                end
            end else begin
                step_q <= step_q + 6'h01;
                case (ph_q)
                    4'h0: begin ph_q <= 4'h1; step_q <= '0; end
                    4'h1: begin ph_q <= 4'h2; step_q <= '0; end
                    // DMA sends one channel nibble here, I/O four address nibbles
                    4'h2: if (step_q == 6'h03 || is_dma) begin
                        ph_q <= is_dma ? 4'h3 : (to_dev ? 4'h4 : 4'h5);
                        step_q <= '0;
                    end
                    4'h3: begin ph_q <= to_dev ? 4'h4 : 4'h5; step_q <= '0; end
                    4'h4: if (step_q == 6'h01) begin ph_q <= 4'h5; step_q <= '0; end
                    4'h5: if (step_q == 6'h01) begin
                        ph_q <= 4'h6;
                        step_q <= '0;
                        nos_q <= '0;
                    end
                    4'h6: begin
                        if (sync_ok) begin
                            rsp_error <= rsp_error || (lad == LPW_SYNC_ERROR);
                            ph_q <= to_dev ? ((lad == LPW_SYNC_READY_MORE) ? 4'h4 : 4'h8)
                                : 4'h7;
                            step_q <= '0;
                        end else if (sync_wait) begin
                            nos_q <= '0;
                        end else if (nos_q == LPW_NO_SYNC_MAX - 4'h1) begin
                            rsp_abort <= 1'b1;
                            ph_q <= 4'h9;
                            step_q <= '0;
                        end else begin
                            nos_q <= nos_q + 4'h1;
                        end
                    end
                    4'h7: if (step_q == 6'h01) begin
                        rd_q <= {lad, rd_q[7:4]};
                        rsp_data <= {lad, rd_q[7:4]};
                        rsp_valid <= 1'b1;
                        step_q <= '0;
                        ph_q <= (is_dma && left_q != 2'h0 && !rsp_error) ? 4'h6 : 4'h8;
                        left_q <= left_q - 2'h1;
                    end else begin
                        rd_q <= {lad, rd_q[7:4]};
                    end
                    4'h8: if (step_q == 6'h01) begin busy_q <= 1'b0; end
                    4'h9: if (step_q == 6'h03) begin busy_q <= 1'b0; end
                    default: busy_q <= 1'b0;
                endcase
            end
        end
    end
    // Abort holds frame low for four clocks
    wire drive = busy_q && (ph_q <= 4'h4 || (ph_q == 4'h5 && step_q == 6'h00));
    assign bus.frame_n = !(busy_q && (ph_q == 4'h0 || ph_q == 4'h9));
    assign bus.lad_h_oe = drive || (busy_q && ph_q == 4'h9);
    assign bus.lad_h_o = (ph_q == 4'h0) ? LPW_START :
        (ph_q == 4'h9) ? LPW_TAR :
        (ph_q == 4'h1) ? ct_q :
        (ph_q == 4'h2) ? addr_q[15 - 4 * step_q[1:0] -: 4] :
        (ph_q == 4'h3) ? {2'h0, left_q == 2'h3 ? LPW_SZ_4 : left_q} :
        (ph_q == 4'h4) ? (step_q[0] ? wd_q[7:4] : wd_q[3:0]) : LPW_TAR;
endmodule
`default_nettype wire

// ===== verification/lpw_checker_props.sv
`timescale 1ns/1ns
`default_nettype none
module lpw_checker
    import lpw_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [3:0] lad_h_o,
    input wire logic lad_h_oe,
    input wire logic [3:0] lad_d_o,
    input wire logic lad_d_oe,
    input wire logic frame_n,
    input wire logic bus_reset_n,
    input wire logic dma_req_n,
    input wire logic [3:0] lad
);
    // ----------------------------------------------------------------
    // Cycle tracking
    // ----------------------------------------------------------------
    logic frame_q;
    logic [3:0] ctype_q;
    logic [9:0] long_cnt_q;
    wire short_w = lad_d_oe && (lad_d_o == LPW_SYNC_SHORT);
    wire long_w = lad_d_oe && (lad_d_o == LPW_SYNC_LONG);
    wire wait_w = short_w || long_w;
    wire host_rd = (ctype_q == LPW_CT_IO_RD) || (ctype_q == LPW_CT_DMA_WR);
    wire ready_w = lad_d_oe && (lad_d_o inside {LPW_SYNC_READY, LPW_SYNC_READY_MORE});
    wire sync_w = ready_w || wait_w || (lad_d_oe && (lad_d_o == LPW_SYNC_ERROR));
    // Type nibble follows the start nibble once frame rises again
    always_ff @(posedge clk_sys) begin
        frame_q <= frame_n;
        if (reset) begin
            ctype_q <= 4'h0;
            long_cnt_q <= 10'h000;
        end else begin
            if (!frame_q && frame_n) begin
                ctype_q <= lad;
            end
            long_cnt_q <= long_w ? long_cnt_q + 10'h001 : 10'h000;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    AST_RESET_QUIET: assert property (!bus_reset_n |-> !lad_d_oe && dma_req_n)
        else $error("target active during bus reset");
    AST_FRAME_RELEASE: assert property (!frame_n |=> !lad_d_oe)
        else $error("target drives after frame");
    AST_ONE_DRIVER: assert property (!(lad_h_oe && lad_d_oe))
        else $error("both ends drive the bus");
    AST_NO_WAIT_SWITCH: assert property (wait_w && $past(wait_w) |-> $stable(lad_d_o))
        else $error("wait code switched");
    AST_WAIT_CLASS: assert property (wait_w |->
        lad_d_o == (ctype_q[3] ? LPW_SYNC_SHORT : LPW_SYNC_LONG))
        else $error("wrong wait code for cycle class");
    AST_SHORT_LIMIT: assert property (short_w [*8] |=> !short_w)
        else $error("short wait run too long");
    AST_LONG_LIMIT: assert property (long_cnt_q <= LPW_LONG_MAX)
        else $error("long wait run too long");
    AST_AFTER_READY: assert property ($past(wait_w) && ready_w && host_rd && frame_n |=>
        lad_d_oe)
        else $error("nothing follows ready sync");
    AST_ERROR_NIBBLES: assert property ($past(wait_w) && lad_d_oe && host_rd &&
        lad_d_o == LPW_SYNC_ERROR |=> lad_d_oe [*2])
        else $error("data nibbles missing after error");
    AST_FIRST_SYNC: assert property ($rose(lad_d_oe) |-> ##[0:2] sync_w)
        else $error("no sync within three clocks");
    // Covers keep an eye on the main traffic
    cover property (short_w ##1 ready_w);
    cover property (long_w ##1 ready_w);
    cover property (lad_d_oe && lad_d_o == LPW_SYNC_ERROR);
    cover property (!frame_n && lad_h_oe && lad_h_o == LPW_START);
endmodule
`default_nettype wire

// ===== verification/lpw_target_bench.sv
`timescale 1ns/1ns
`default_nettype none
module lpw_target_bench
    import lpw_pkg::*;
;
    logic clk_sys, reset, req_valid, slow_io, slow_ready, err_inject, dma_want;
    logic src_valid, snk_ready;
    logic [3:0] req_type;
    logic [15:0] req_addr;
    logic [1:0] req_size;
    logic [7:0] req_wdata, src_data, rsp_data, snk_data, wd;
    logic req_ready, rsp_valid, rsp_error, rsp_abort, dma_seen, src_ready, snk_valid;
    logic cyc_done, cyc_error;
    int miscompares, samples_checked, waits_seen, nrx, nsnk, dones, aborts, errs, src_idx;
    int w0, n0, s0, d0, a0, e0, i0, nb;
    logic [7:0] got [0:63];
    logic [7:0] sunk [0:63];
    localparam logic [15:0] BASE = 16'h02E8;
    // Target data avoids sync-like nibbles so wait tracking on the wire stays unambiguous
    localparam logic [7:0] SRC [0:7] = '{8'h3C, 8'hB7, 8'h12, 8'h4D, 8'hE8, 8'h71, 8'h2B, 8'hC4};
    localparam logic [1:0] SZS [0:2] = '{LPW_SZ_1, LPW_SZ_2, LPW_SZ_4};
    lpw_bus_if bus_i ();
    lpw_host lpw_host_i (.clk_sys(clk_sys), .reset(reset), .bus(bus_i),
        .req_valid(req_valid), .req_ready(req_ready), .req_type(req_type),
        .req_addr(req_addr), .req_size(req_size), .req_wdata(req_wdata),
        .rsp_data(rsp_data), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
        .rsp_abort(rsp_abort), .dma_seen(dma_seen));
    lpw_target lpw_target_i (.clk_sys(clk_sys), .reset(reset), .bus(bus_i),
        .io_base(BASE), .slow_io(slow_io), .slow_ready(slow_ready), .err_inject(err_inject),
        .dma_want(dma_want), .dma_chan(2'h1), .src_data(src_data), .src_valid(src_valid),
        .src_ready(src_ready), .snk_data(snk_data), .snk_valid(snk_valid),
        .snk_ready(snk_ready), .cyc_done(cyc_done), .cyc_error(cyc_error));
    lpw_checker lpw_checker_i (.clk_sys(clk_sys), .reset(reset), .lad_h_o(bus_i.lad_h_o),
        .lad_h_oe(bus_i.lad_h_oe), .lad_d_o(bus_i.lad_d_o), .lad_d_oe(bus_i.lad_d_oe),
        .frame_n(bus_i.frame_n), .bus_reset_n(bus_i.bus_reset_n),
        .dma_req_n(bus_i.dma_req_n), .lad(bus_i.lad));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // ----------------------------------------------------------------
    // Monitor and source feeder
    // ----------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (bus_i.lad_d_oe === 1'b1 && bus_i.lad inside {LPW_SYNC_SHORT, LPW_SYNC_LONG}) begin
            waits_seen++;
        end
        if (rsp_valid === 1'b1) begin
            got[nrx] = rsp_data;
            nrx++;
        end
        if (snk_valid === 1'b1 && snk_ready === 1'b1) begin
            sunk[nsnk] = snk_data;
            nsnk++;
        end
        if (src_ready === 1'b1) begin
            src_idx++;
            src_data <= SRC[src_idx % 8];
        end
        dones += int'(cyc_done === 1'b1);
        aborts += int'(rsp_abort === 1'b1);
        errs += int'(cyc_error === 1'b1);
        slow_ready <= slow_io && (waits_seen - w0 >= 40);
    end
    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task automatic give_verdict;
        $display("checked %0d mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wait_ready(input int lim);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < lim) begin
            @(posedge clk_sys);
            n++;
        end
        if (n == lim) begin
            chk(1'b0, "host never ready");
            give_verdict();
        end
    endtask
    // One host transfer, counters snapshotted before the request is raised
    task automatic run(input logic [3:0] t, input logic [15:0] a, input logic [1:0] sz);
        w0 = waits_seen;
        n0 = nrx;
        s0 = nsnk;
        d0 = dones;
        a0 = aborts;
        e0 = errs;
        i0 = src_idx;
        @(posedge clk_sys);
        req_type <= t;
        req_addr <= a;
        req_size <= sz;
        req_wdata <= wd;
        req_valid <= 1'b1;
        @(posedge clk_sys);
        wait_ready(50);
        req_valid <= 1'b0;
        @(posedge clk_sys);
        wait_ready(800);
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic ask_dma;
        int n;
        n = 0;
        @(posedge clk_sys);
        dma_want <= 1'b1;
        @(posedge clk_sys);
        dma_want <= 1'b0;
        while (dma_seen !== 1'b1 && n < 40) begin
            @(posedge clk_sys);
            n++;
        end
        chk(dma_seen === 1'b1, "dma request not seen");
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {req_valid, slow_io, slow_ready, err_inject, dma_want, snk_ready} = '0;
        {req_type, req_addr, req_size, req_wdata, wd} = '0;
        {miscompares, samples_checked, waits_seen, nrx, nsnk, dones, aborts, errs} = '0;
        {src_idx, w0} = '0;
        src_data = SRC[0];
        src_valid = 1'b1;
        reset = 1'b1;
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        wait_ready(20000);
        run(LPW_CT_IO_RD, BASE, LPW_SZ_1);
        chk(nrx - n0 == 1 && got[n0] === SRC[i0 % 8], "io read data");
        chk(waits_seen - w0 == 3 && dones - d0 == 1, "io read waits");
        $display("test io_read ended");
        for (int i = 1; i <= LPW_FIFO_DEPTH; i++) begin
            wd = 8'h11 * 8'(i);
            run(LPW_CT_IO_WR, BASE, LPW_SZ_1);
            chk(waits_seen - w0 == 2, "io write waits");
        end
        chk(snk_valid === 1'b1 && nsnk == 0, "fifo not holding");
        snk_ready <= 1'b1;
        repeat (LPW_FIFO_DEPTH + 4) @(posedge clk_sys);
        for (int i = 0; i < LPW_FIFO_DEPTH; i++) begin
            chk(sunk[i] === 8'h11 * 8'(i + 1), "fifo order");
        end
        $display("test io_write ended");
        for (int k = 0; k < 6; k++) begin
            nb = (k % 3 == 2) ? 4 : k % 3 + 1;
            ask_dma();
            run(k < 3 ? LPW_CT_DMA_RD : LPW_CT_DMA_WR, 16'h0000, SZS[k % 3]);
            if (k < 3) begin
                chk(nsnk - s0 == nb, "dma read count");
            end else begin
                chk(nrx - n0 == nb && got[n0 + nb - 1] === SRC[(i0 + nb - 1) % 8], "dma wr");
            end
            if (nb == 1) begin
                chk(waits_seen - w0 == (k < 3 ? 3 : 4), "dma waits");
            end
        end
        $display("test dma ended");
        err_inject <= 1'b1;
        run(LPW_CT_IO_RD, BASE, LPW_SZ_1);
        chk(rsp_error === 1'b1 && errs - e0 == 1 && nrx - n0 == 1, "error read");
        ask_dma();
        run(LPW_CT_DMA_WR, 16'h0000, LPW_SZ_4);
        chk(rsp_error === 1'b1 && nrx - n0 == 1, "error multi byte");
        err_inject <= 1'b0;
        $display("test error ended");
        run(LPW_CT_IO_RD, BASE + 16'h0010, LPW_SZ_1);
        chk(aborts - a0 == 1 && nrx == n0 && dones == d0, "miss not ignored");
        run(LPW_CT_IO_RD, BASE, LPW_SZ_1);
        chk(nrx - n0 == 1 && rsp_error === 1'b0, "no recovery");
        $display("test miss ended");
        slow_io <= 1'b1;
        run(LPW_CT_IO_RD, BASE, LPW_SZ_1);
        chk(waits_seen - w0 >= 40 && waits_seen - w0 <= 330 && nrx - n0 == 1, "slow io");
        slow_io <= 1'b0;
        $display("test slow_io ended");
        give_verdict();
    end
endmodule
`default_nettype wire
